// [sfr_array.sv]
// byte array behind the read path, with a load port for its content
`timescale 1ns/10ps
`default_nettype none
module sfr_array
  import sfr_pkg::*;
(
  // clock
  input  wire logic                  clk_in,
  // content load
  input  wire logic                  wr_en_in,
  input  wire logic [SFR_MEM_AW-1:0] wr_addr_in,
  input  wire logic [7:0]            wr_data_in,
  // read port, one cycle latency
  input  wire logic [SFR_MEM_AW-1:0] rd_addr_in,
  output logic      [7:0]            rd_data_out
);

  logic [7:0] mem_r [0:(1<<SFR_MEM_AW)-1];

  // no reset on the array: content is non-volatile by intent
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
  end

  // registered read keeps the data output on a flip-flop
  always_ff @(posedge clk_in) begin
    rd_data_out <= mem_r[rd_addr_in];
  end

endmodule
`default_nettype wire

// [sfr_host_model.sv]
// host controller model driving the serial link of the read path
`timescale 1ns/10ps
`default_nettype none
module sfr_host_model (
  // clock
  input  wire logic       clk_in,
  // device side of the lanes
  input  wire logic [3:0] dev_in,
  input  wire logic [3:0] dev_oe_in,
  // link
  output logic            sck_out,
  output logic            cs_n_out,
  output logic [3:0]      lane_out
);
  logic [3:0] drv_r;
  logic [3:0] oe_r;
  logic [3:0] last_r;

  // idle: link clock low, nothing selected
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    drv_r = 4'h0;
    oe_r = 4'h0;
    last_r = 4'h0;
  end

  // undriven lanes hold the inverse of their last driven level, no pulls modelled
  assign lane_out = (dev_oe_in & dev_in) | (~dev_oe_in & oe_r & drv_r)
                  | (~dev_oe_in & ~oe_r & ~last_r);

  // remember only driven levels, so a floating lane stays put instead of toggling
  always @(posedge clk_in) begin
    last_r <= ((dev_oe_in | oe_r) & lane_out) | (~(dev_oe_in | oe_r) & last_r);
  end

  // select while the link clock is low
  task automatic frame_begin();
    @(posedge clk_in);
    cs_n_out <= 1'b0;
  endtask

  // one link clock: 3 clk low, 2 clk high; device data read just before rise
  task automatic xfer(input logic [3:0] drv, input logic [3:0] oe,
                      output logic [3:0] seen, output logic [3:0] seen_oe);
    @(posedge clk_in);
    sck_out <= 1'b0;
    drv_r <= drv;
    oe_r <= oe;
    repeat (2) @(posedge clk_in);
    @(posedge clk_in);
    seen = lane_out;
    seen_oe = dev_oe_in;
    sck_out <= 1'b1;
    @(posedge clk_in);
  endtask

  // deselect ends the command and releases the lanes
  task automatic frame_end();
    @(posedge clk_in);
    cs_n_out <= 1'b1;
    sck_out <= 1'b0;
    oe_r <= 4'h0;
    repeat (3) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// [sfr_pkg.sv]
// shared constants, states and carriers for the serial flash read path
package sfr_pkg;

  // instruction codes
  localparam logic [7:0] SFR_OP_READ     = 8'h03;
  localparam logic [7:0] SFR_OP_FAST     = 8'h0b;
  localparam logic [7:0] SFR_OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] SFR_OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] SFR_OP_DUAL_IO  = 8'hbb;
  localparam logic [7:0] SFR_OP_MODE_RST = 8'hff;

  // bit and clock counts of the frame phases
  localparam logic [4:0] SFR_CMD_BITS    = 5'h08;
  localparam logic [4:0] SFR_ADDR_BITS   = 5'h18;
  localparam logic [4:0] SFR_MODE_BITS   = 5'h08;
  localparam logic [3:0] SFR_FIXED_DUMMY = 4'h8;
  localparam logic [3:0] SFR_DIO_MODE_CK = 4'h4;
  localparam logic [3:0] SFR_NO_DUMMY    = 4'h0;

  // continuous-mode select value that skips the instruction byte
  localparam logic [1:0] SFR_CONT_SEL    = 2'h2;
  localparam int         SFR_MODE_RST_BIT = 4;
  localparam logic [7:0] SFR_MODE_RESET  = 8'h10;

  // lanes per clock
  localparam logic [2:0] SFR_W1 = 3'h1;
  localparam logic [2:0] SFR_W2 = 3'h2;
  localparam logic [2:0] SFR_W4 = 3'h4;

  // modelled array: 1 KiB, highest location wraps to zero
  localparam int          SFR_MEM_AW     = 10;
  localparam logic [23:0] SFR_ARRAY_LAST = 24'h0003ff;
  localparam logic [23:0] SFR_ADDR_RESET = 24'h000000;

  typedef enum logic [2:0] {
    SFR_ST_CMD,
    SFR_ST_ADDR,
    SFR_ST_MODE,
    SFR_ST_DUMMY,
    SFR_ST_DATA,
    SFR_ST_IGNORE
  } sfr_state_t;

  // per-command shape of the frame
  typedef struct packed {
    logic [2:0] addr_w;
    logic [2:0] out_w;
    logic       mode_en;
    logic [3:0] dummy;
  } sfr_cfg_t;

  localparam sfr_cfg_t SFR_CFG_RESET = '{addr_w: 3'h1, out_w: 3'h1, mode_en: 1'b0,
                                         dummy: 4'h0};

endpackage

// [sfr_read_path.sv]
// serial flash read command path: single, dual and quad reads from the array
`timescale 1ns/10ps
`default_nettype none
module sfr_read_path
  import sfr_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  // serial link, sampled on clk_in
  input  wire logic                  sck_in,
  input  wire logic                  cs_n_in,
  input  wire logic [3:0]            io_lane_in,
  output logic      [3:0]            io_lane_out,
  output logic      [3:0]            io_lane_oe_out,
  // status and configuration bits
  input  wire logic                  busy_in,
  input  wire logic                  quad_enable_bit_in,
  input  wire logic                  var_latency_en_in,
  input  wire logic [3:0]            latency_ctrl_in,
  // array content load
  input  wire logic                  mem_wr_en_in,
  input  wire logic [SFR_MEM_AW-1:0] mem_wr_addr_in,
  input  wire logic [7:0]            mem_wr_data_in,
  // observation
  output logic                       cont_mode_out,
  output logic      [7:0]            mode_byte_out
);

  sfr_state_t  st_r;
  sfr_cfg_t    cfg_r;
  sfr_cfg_t    dec_cfg;
  logic        dec_ok;
  logic        sck_q_r;
  logic        sck_rise;
  logic        sck_fall;
  logic        link_rise;
  logic [4:0]  cnt_r;
  logic [4:0]  cnt_step;
  logic [7:0]  cmd_sh_r;
  logic [7:0]  cmd_full;
  logic [23:0] addr_sh_r;
  logic [23:0] addr_full;
  logic [23:0] addr_r;
  logic [7:0]  mode_sh_r;
  logic [7:0]  mode_full;
  logic        cont_r;
  logic [7:0]  mode_r;
  logic [7:0]  out_sh_r;
  logic [3:0]  pos_r;
  logic [3:0]  io_out_r;
  logic [3:0]  oe_r;
  logic [7:0]  rd_data;
  logic [3:0]  fixed_or_var;
  logic [3:0]  dio_dummy;
  logic        byte_start;

  // link clock edges seen at clk_in; sck must stay at least two clk per phase
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sck_q_r <= 1'b0;
    end else begin
      sck_q_r <= sck_in;
    end
  end

  assign sck_rise   = sck_in & ~sck_q_r;
  assign sck_fall   = ~sck_in & sck_q_r;
  assign link_rise  = sck_rise & ~cs_n_in;
  assign byte_start = sck_fall & ~cs_n_in & (st_r == SFR_ST_DATA) & (pos_r == 4'h0);

  // incoming bits of each phase, upper lane first
  always_comb begin
    cmd_full  = {cmd_sh_r[6:0], io_lane_in[0]};
    mode_full = {mode_sh_r[5:0], io_lane_in[1:0]};
    if (cfg_r.addr_w == SFR_W2) begin
      addr_full = {addr_sh_r[21:0], io_lane_in[1:0]};
    end else begin
      addr_full = {addr_sh_r[22:0], io_lane_in[0]};
    end
    cnt_step = cnt_r + {2'h0, cfg_r.addr_w};
  end

  // latency: fixed eight, or the latency field when enabled
  assign fixed_or_var = var_latency_en_in ? latency_ctrl_in : SFR_FIXED_DUMMY;
  // mode clocks come out of the total latency on the dual address read
  assign dio_dummy = (var_latency_en_in && latency_ctrl_in > SFR_DIO_MODE_CK) ?
                     latency_ctrl_in - SFR_DIO_MODE_CK : SFR_NO_DUMMY;

  // instruction decode into a frame shape
  always_comb begin
    dec_cfg = SFR_CFG_RESET;
    dec_ok  = 1'b1;
    case (cmd_full)
      SFR_OP_READ: begin
        dec_ok = ~busy_in;
      end
      SFR_OP_FAST: begin
        dec_cfg.dummy = fixed_or_var;
      end
      SFR_OP_DUAL_OUT: begin
        dec_cfg.dummy = fixed_or_var;
        dec_cfg.out_w = SFR_W2;
      end
      SFR_OP_QUAD_OUT: begin
        dec_ok        = quad_enable_bit_in;
        dec_cfg.dummy = fixed_or_var;
        dec_cfg.out_w = SFR_W4;
      end
      SFR_OP_DUAL_IO: begin
        dec_cfg.addr_w  = SFR_W2;
        dec_cfg.out_w   = SFR_W2;
        dec_cfg.mode_en = 1'b1;
        dec_cfg.dummy   = dio_dummy;
      end
      default: begin
        dec_ok = 1'b0;
      end
    endcase
  end

  // frame sequencer; chip select high rearms for the next frame
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r  <= SFR_ST_CMD;
      cfg_r <= SFR_CFG_RESET;
      cnt_r <= 5'h00;
    end else if (cs_n_in) begin
      cnt_r <= 5'h00;
      if (cont_r) begin
        st_r           <= SFR_ST_ADDR;
        cfg_r          <= SFR_CFG_RESET;
        cfg_r.addr_w   <= SFR_W2;
        cfg_r.out_w    <= SFR_W2;
        cfg_r.mode_en  <= 1'b1;
        cfg_r.dummy    <= dio_dummy;
      end else begin
        st_r  <= SFR_ST_CMD;
        cfg_r <= SFR_CFG_RESET;
      end
    end else if (link_rise) begin
      case (st_r)
        SFR_ST_CMD: begin
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == SFR_CMD_BITS - 5'h01) begin
            cnt_r <= 5'h00;
            cfg_r <= dec_cfg;
            st_r  <= dec_ok ? SFR_ST_ADDR : SFR_ST_IGNORE;
          end
        end
        SFR_ST_ADDR: begin
          cnt_r <= cnt_step;
          if (cnt_step == SFR_ADDR_BITS) begin
            cnt_r <= 5'h00;
            if (cfg_r.mode_en) begin
              st_r <= SFR_ST_MODE;
            end else if (cfg_r.dummy == SFR_NO_DUMMY) begin
              st_r <= SFR_ST_DATA;
            end else begin
              st_r <= SFR_ST_DUMMY;
            end
          end
        end
        SFR_ST_MODE: begin
          cnt_r <= cnt_r + 5'h02;
          if (cnt_r + 5'h02 == SFR_MODE_BITS) begin
            cnt_r <= 5'h00;
            st_r  <= (cfg_r.dummy == SFR_NO_DUMMY) ? SFR_ST_DATA : SFR_ST_DUMMY;
          end
        end
        SFR_ST_DUMMY: begin
          // lane levels are not looked at while counting
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r + 5'h01 == {1'b0, cfg_r.dummy}) begin
            cnt_r <= 5'h00;
            st_r  <= SFR_ST_DATA;
          end
        end
        default: begin
          cnt_r <= cnt_r;
        end
      endcase
    end
  end

  // shift registers catch lane bits on the link rising edge only
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cmd_sh_r  <= 8'h00;
      addr_sh_r <= 24'h000000;
      mode_sh_r <= 8'h00;
    end else if (link_rise) begin
      if (st_r == SFR_ST_CMD) begin
        cmd_sh_r <= cmd_full;
      end
      if (st_r == SFR_ST_ADDR) begin
        addr_sh_r <= addr_full;
      end
      if (st_r == SFR_ST_MODE) begin
        mode_sh_r <= mode_full;
      end
    end
  end

  // read address: loaded after the last address bit, stepped per byte
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      addr_r <= SFR_ADDR_RESET;
    end else if (link_rise && st_r == SFR_ST_ADDR && cnt_step == SFR_ADDR_BITS) begin
      addr_r <= addr_full;
    end else if (byte_start) begin
      if (addr_r == SFR_ARRAY_LAST) begin
        addr_r <= SFR_ADDR_RESET;
      end else begin
        addr_r <= addr_r + 24'h000001;
      end
    end
  end

  // continuous mode: decided by bits 5..4 of the mode byte, low nibble unused
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cont_r <= 1'b0;
      mode_r <= SFR_MODE_RESET;
    end else if (link_rise && st_r == SFR_ST_MODE && cnt_r + 5'h02 == SFR_MODE_BITS) begin
      mode_r <= mode_full;
      cont_r <= (mode_full[5:4] == SFR_CONT_SEL);
    end else if (link_rise && st_r == SFR_ST_CMD && cnt_r == SFR_CMD_BITS - 5'h01 &&
                 cmd_full == SFR_OP_MODE_RST) begin
      mode_r[SFR_MODE_RST_BIT] <= 1'b1;
      cont_r                   <= 1'b0;
    end
  end

  // place the top bits of a byte on the lanes for the chosen width
  function automatic logic [3:0] sfr_lanes(input logic [7:0] b, input logic [2:0] w);
    logic [3:0] l;
    l = 4'h0;
    if (w == SFR_W4) begin
      l = b[7:4];
    end else if (w == SFR_W2) begin
      l = {2'h0, b[7:6]};
    end else begin
      l = {2'h0, b[7], 1'b0};
    end
    return l;
  endfunction

  function automatic logic [3:0] sfr_oe(input logic [2:0] w);
    logic [3:0] m;
    m = 4'h2;
    if (w == SFR_W4) begin
      m = 4'hf;
    end else if (w == SFR_W2) begin
      m = 4'h3;
    end
    return m;
  endfunction

  // output: within a frame, enable and bits change on falling edges only, host has released lanes
  always_ff @(posedge clk_in) begin
    if (rst_in || cs_n_in) begin
      io_out_r <= 4'h0;
      oe_r     <= 4'h0;
      out_sh_r <= 8'h00;
      pos_r    <= 4'h0;
    end else if (sck_fall && st_r == SFR_ST_DATA) begin
      oe_r <= sfr_oe(cfg_r.out_w);
      if (pos_r == 4'h0) begin
        io_out_r <= sfr_lanes(rd_data, cfg_r.out_w);
        out_sh_r <= rd_data << cfg_r.out_w;
      end else begin
        io_out_r <= sfr_lanes(out_sh_r, cfg_r.out_w);
        out_sh_r <= out_sh_r << cfg_r.out_w;
      end
      if (pos_r + {1'b0, cfg_r.out_w} == 4'h8) begin
        pos_r <= 4'h0;
      end else begin
        pos_r <= pos_r + {1'b0, cfg_r.out_w};
      end
    end
  end

  assign io_lane_out    = io_out_r;
  assign io_lane_oe_out = oe_r;
  assign cont_mode_out  = cont_r;
  assign mode_byte_out  = mode_r;

  // array read follows the address; ready well before the next byte start
  sfr_array u_array (
    .clk_in      (clk_in),
    .wr_en_in    (mem_wr_en_in),
    .wr_addr_in  (mem_wr_addr_in),
    .wr_data_in  (mem_wr_data_in),
    .rd_addr_in  (addr_r[SFR_MEM_AW-1:0]),
    .rd_data_out (rd_data)
  );

  // checks
  sequence s_cmd_last;
    link_rise && st_r == SFR_ST_CMD && cnt_r == SFR_CMD_BITS - 5'h01;
  endsequence

  sequence s_byte_step;
    byte_start && addr_r != SFR_ARRAY_LAST;
  endsequence

  a_busy_read_drop: assert property (@(posedge clk_in) disable iff (rst_in)
    s_cmd_last and (cmd_full == SFR_OP_READ && busy_in) |=> st_r == SFR_ST_IGNORE)
    else $error("plain read taken while busy");

  a_quad_gate_off: assert property (@(posedge clk_in) disable iff (rst_in)
    s_cmd_last and (cmd_full == SFR_OP_QUAD_OUT && !quad_enable_bit_in)
    |=> st_r == SFR_ST_IGNORE ##1 io_lane_oe_out == 4'h0)
    else $error("quad read taken with quad enable clear");

  a_frame_end_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
    cs_n_in |=> io_lane_oe_out == 4'h0 && st_r != SFR_ST_DATA)
    else $error("output still driven after chip select high");

  a_addr_step_one: assert property (@(posedge clk_in) disable iff (rst_in)
    s_byte_step |=> addr_r == $past(addr_r) + 24'h000001)
    else $error("address did not advance by one");

  a_addr_wrap_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    byte_start && addr_r == SFR_ARRAY_LAST |=> addr_r == SFR_ADDR_RESET)
    else $error("address did not wrap to zero");

  a_out_on_fall: assert property (@(posedge clk_in) disable iff (rst_in)
    $changed(io_lane_out) && !$past(cs_n_in) |-> $past(sck_fall))
    else $error("data lanes changed off a falling edge");

  a_addr_on_rise: assert property (@(posedge clk_in) disable iff (rst_in)
    $changed(addr_sh_r) |-> $past(link_rise))
    else $error("address bit taken off a rising edge");

  a_cont_skip_cmd: assert property (@(posedge clk_in) disable iff (rst_in)
    cs_n_in && cont_r |=> st_r == SFR_ST_ADDR && cfg_r.addr_w == SFR_W2)
    else $error("continuous frame did not start at address");

  a_normal_frame: assert property (@(posedge clk_in) disable iff (rst_in)
    cs_n_in && !cont_r |=> st_r == SFR_ST_CMD)
    else $error("normal frame did not expect instruction");

  a_fixed_dummy: assert property (@(posedge clk_in) disable iff (rst_in)
    s_cmd_last and (cmd_full == SFR_OP_FAST && !var_latency_en_in)
    |=> cfg_r.dummy == SFR_FIXED_DUMMY)
    else $error("fast read dummy count not eight");

  a_quad_lanes_on: assert property (@(posedge clk_in) disable iff (rst_in)
    sck_fall && !cs_n_in && st_r == SFR_ST_DATA && cfg_r.out_w == SFR_W4
    |=> io_lane_oe_out == 4'hf)
    else $error("quad data not on four lanes");

endmodule
`default_nettype wire

// [tb_top.sv]
// testbench: host read sequences against the serial flash read path
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import sfr_pkg::*;
;
  // clock, reset, status
  logic             clk_in = 1'b0;
  logic             rst_in = 1'b1;
  logic             busy = 1'b0;
  logic             qe = 1'b0;
  logic             vlat = 1'b0;
  logic [3:0]       lat = 4'h0;
  // array load
  logic             wr_en = 1'b0;
  logic [9:0]       wr_addr = 10'h000;
  logic [7:0]       wr_data = 8'h00;
  // link and observation
  wire logic        sck;
  wire logic        cs_n;
  wire logic [3:0]  lane;
  wire logic [3:0]  dev;
  wire logic [3:0]  dev_oe;
  wire logic        cont;
  wire logic [7:0]  mode;
  int               n_fail = 0;
  int               tests_run = 0;

  always #25 clk_in = ~clk_in;

  sfr_read_path uut (
    .clk_in(clk_in), .rst_in(rst_in), .sck_in(sck), .cs_n_in(cs_n),
    .io_lane_in(lane), .io_lane_out(dev), .io_lane_oe_out(dev_oe),
    .busy_in(busy), .quad_enable_bit_in(qe), .var_latency_en_in(vlat),
    .latency_ctrl_in(lat), .mem_wr_en_in(wr_en), .mem_wr_addr_in(wr_addr),
    .mem_wr_data_in(wr_data), .cont_mode_out(cont), .mode_byte_out(mode));

  sfr_host_model host (
    .clk_in(clk_in), .dev_in(dev), .dev_oe_in(dev_oe),
    .sck_out(sck), .cs_n_out(cs_n), .lane_out(lane));

  // array pattern, distinct enough to catch address slips
  function automatic logic [7:0] pat(input logic [23:0] a);
    return (a[7:0] * 8'h1d) ^ {6'h2a, a[9:8]};
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // n link clocks, w bits each from the top of v
  task automatic send(input logic [31:0] v, input int n, input int w, input logic [3:0] oe);
    logic [3:0] s;
    logic [3:0] so;
    for (int i = 0; i < n; i++) begin
      host.xfer((w == 1) ? {3'h0, v[31]} : {2'h0, v[31:30]}, oe, s, so);
      v = v << w;
    end
  endtask

  // instruction then address, serial or two lanes
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int w);
    host.frame_begin();
    send({op, 24'h0}, 8, 1, 4'h1);
    send({a, 8'h0}, 24 / w, w, (w == 1) ? 4'h1 : 4'h3);
  endtask

  // read n bytes of width w, host lanes released
  task automatic rd(input int w, input int n, input logic [23:0] a, input logic [3:0] eoe);
    logic [3:0] s;
    logic [3:0] so;
    logic [7:0] got;
    for (int b = 0; b < n; b++) begin
      got = 8'h00;
      for (int k = 0; k < 8 / w; k++) begin
        host.xfer(4'h0, 4'h0, s, so);
        got = (w == 4) ? {got[3:0], s} : (w == 2) ? {got[5:0], s[1:0]} : {got[6:0], s[1]};
      end
      chk("lane enables", {4'h0, eoe}, {4'h0, so});
      chk("read byte", pat((a + 24'(b)) & SFR_ARRAY_LAST), got);
    end
  endtask

  // device must stay off the lanes for n clocks
  task automatic none(input int n);
    logic [3:0] s;
    logic [3:0] so;
    for (int i = 0; i < n; i++) begin
      host.xfer(4'h0, 4'h0, s, so);
      chk("idle enables", 8'h00, {4'h0, so});
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge clk_in);
    n_fail++;
    $display("BAD run length expected done seen hang");
    finish_test();
  end

  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    // array content, not covered by reset
    for (int i = 0; i < 1024; i++) begin
      @(posedge clk_in);
      wr_en <= 1'b1;
      wr_addr <= i[9:0];
      wr_data <= pat(24'(i));
    end
    @(posedge clk_in);
    wr_en <= 1'b0;
    chk("mode byte", 8'h10, mode);
    chk("cont mode", 8'h00, {7'h0, cont});
    // plain read over the top of the array, cut mid-byte
    cmd(SFR_OP_READ, 24'h0003fe, 1);
    rd(1, 3, 24'h0003fe, 4'h2);
    send(32'h0, 4, 1, 4'h0);
    host.frame_end();
    chk("enables after cs", 8'h00, {4'h0, dev_oe});
    // plain read while busy
    busy <= 1'b1;
    cmd(SFR_OP_READ, 24'h000010, 1);
    none(8);
    host.frame_end();
    busy <= 1'b0;
    // fast read, junk on input during dummies, then variable latency
    cmd(SFR_OP_FAST, 24'h000020, 1);
    send(32'ha5a5a5a5, 8, 1, 4'h1);
    rd(1, 2, 24'h000020, 4'h2);
    host.frame_end();
    vlat <= 1'b1;
    lat <= 4'h3;
    cmd(SFR_OP_FAST, 24'h000030, 1);
    send(32'h5a000000, 3, 1, 4'h1);
    rd(1, 2, 24'h000030, 4'h2);
    host.frame_end();
    vlat <= 1'b0;
    // dual output
    cmd(SFR_OP_DUAL_OUT, 24'h000123, 1);
    send(32'hffffffff, 8, 1, 4'h1);
    rd(2, 3, 24'h000123, 4'h3);
    host.frame_end();
    // quad output refused without quad enable, then accepted
    cmd(SFR_OP_QUAD_OUT, 24'h000040, 1);
    none(10);
    host.frame_end();
    qe <= 1'b1;
    cmd(SFR_OP_QUAD_OUT, 24'h0003ff, 1);
    send(32'h0, 8, 1, 4'h1);
    rd(4, 3, 24'h0003ff, 4'hf);
    host.frame_end();
    qe <= 1'b0;
    // dual io arming continuous mode, low mode nibble floated
    cmd(SFR_OP_DUAL_IO, 24'h000200, 2);
    send(32'h20000000, 2, 2, 4'h3);
    send(32'h0, 2, 2, 4'h0);
    rd(2, 2, 24'h000200, 4'h3);
    host.frame_end();
    chk("mode select", 8'h02, {6'h0, mode[5:4]});
    chk("cont mode", 8'h01, {7'h0, cont});
    // frame without instruction, latency six, mode 00 disarms
    vlat <= 1'b1;
    lat <= 4'h6;
    host.frame_begin();
    send({24'h0002f0, 8'h0}, 12, 2, 4'h3);
    send(32'h0, 4, 2, 4'h3);
    send(32'h0, 2, 2, 4'h0);
    rd(2, 2, 24'h0002f0, 4'h3);
    host.frame_end();
    vlat <= 1'b0;
    chk("cont mode", 8'h00, {7'h0, cont});
    cmd(SFR_OP_READ, 24'h000055, 1);
    rd(1, 1, 24'h000055, 4'h2);
    host.frame_end();
    // all-ones instruction in normal mode sets mode bit four again
    chk("mode bit four", 8'h00, {7'h0, mode[4]});
    host.frame_begin();
    send(32'hff000000, 8, 1, 4'h1);
    host.frame_end();
    chk("mode bit four", 8'h01, {7'h0, mode[4]});
    // arm again, leave with the all-ones pattern
    cmd(SFR_OP_DUAL_IO, 24'h000000, 2);
    send(32'ha0000000, 4, 2, 4'h3);
    rd(2, 1, 24'h000000, 4'h3);
    host.frame_end();
    chk("cont mode", 8'h01, {7'h0, cont});
    host.frame_begin();
    send(32'hffffffff, 16, 2, 4'h3);
    host.frame_end();
    chk("mode bit four", 8'h01, {7'h0, mode[4]});
    chk("cont mode", 8'h00, {7'h0, cont});
    finish_test();
  end
endmodule
`default_nettype wire
